// ==== rtl/wfp_pkg.sv ====
// ****************************************************************
// wake payload and fd configuration constants
// ****************************************************************
package wfp_pkg;
	localparam int ADDR_W = 7;
	localparam int DATA_W = 16;
	localparam int PAY_WORDS = 4;
	localparam int PAY_BYTES = 8;

	// register offsets
	localparam logic [6:0] ADDR_PAY_7_6 = 7'h37;
	localparam logic [6:0] ADDR_PAY_5_4 = 7'h38;
	localparam logic [6:0] ADDR_PAY_3_2 = 7'h39;
	localparam logic [6:0] ADDR_PAY_1_0 = 7'h3A;
	localparam logic [6:0] ADDR_FD_CFG = 7'h3B;
	localparam logic [6:0] ADDR_TRIM = 7'h3C;

	// fd configuration fields
	localparam int FD_EN_BIT = 0;
	localparam int FD_FILT_LSB = 1;
	localparam int FD_FILT_W = 3;
	localparam int FD_SUSP_BIT = 5;
	localparam logic [15:0] FD_READ_MASK = 16'h002F;
	localparam logic [15:0] FD_RESET = 16'h0000;

	// trim and option fields
	localparam int TRIM_RXSEL_BIT = 14;
	localparam int TRIM_TC_LSB = 7;
	localparam int TRIM_TC_W = 5;
	localparam int OSC_TRIM_LSB = 0;
	localparam int OSC_TRIM_W = 7;
	localparam logic [15:0] TRIM_READ_MASK = 16'h4FFF;
	localparam logic [15:0] TRIM_RESET = 16'h0000;
	localparam logic [1:0] TRIM_KEY_OPEN = 2'h3;
	localparam logic [15:0] PAY_RESET = 16'h0000;

	// length code
	localparam logic [3:0] DLC_MAX_BYTES = 4'h8;

	// dominant filter timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int FILT_STEP_NS = 50;
	localparam int FILT_LONG_NS = 775;
	localparam logic [2:0] FILT_LONG_CODE = 3'h7;
	localparam int FILT_CYC_W = 7;
	localparam logic [6:0] FILT_SHORT_CYC = 7'((FILT_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [6:0] FILT_LONG_CYC = 7'((FILT_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// filter time in clock cycles, rounded up
	function automatic logic [6:0] wfp_filter_cycles(input logic [2:0] code);
		int ns;
		ns = (code == FILT_LONG_CODE) ? FILT_LONG_NS : (int'(code) + 1) * FILT_STEP_NS;
		return 7'((ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	endfunction : wfp_filter_cycles
endpackage : wfp_pkg

// ==== rtl/wfp_payload_store.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// payload word store, registered read
// ****************************************************************
module wfp_payload_store
	import wfp_pkg::*;
#(
	parameter int WORDS = PAY_WORDS
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ce,
	// write port
	input wire logic wr_en,
	input wire logic [1:0] wr_idx,
	input wire logic [15:0] wr_data,
	// read port
	input wire logic [1:0] rd_idx,
	output logic [15:0] rd_data_q,
	// whole contents, word k holds bytes 2k+1 and 2k
	output logic [WORDS*16-1:0] flat
);
	logic [15:0] mem_q [WORDS];
	logic [15:0] mem_d [WORDS];
	logic [15:0] rd_data_d;

	always_comb begin
		for (int k = 0; k < WORDS; k++) begin
			mem_d[k] = mem_q[k];
			flat[k*16 +: 16] = mem_q[k];
		end
		if (wr_en) begin
			mem_d[wr_idx] = wr_data;
		end
		rd_data_d = mem_q[rd_idx];
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			for (int k = 0; k < WORDS; k++) begin
				mem_q[k] <= PAY_RESET;
			end
			rd_data_q <= PAY_RESET;
		end else if (ce) begin
			mem_q <= mem_d;
			rd_data_q <= rd_data_d;
		end
	end
endmodule : wfp_payload_store
`default_nettype wire

// ==== rtl/wfp_config.sv ====
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - four 16-bit payload registers each hold two wake bytes, odd byte high, even byte low.
// - fd bit 0 enables the fd tolerant mode when one and disables it when zero.
// - fd bits 3:1 pick 50 ns to 350 ns in 50 ns steps for codes 0 to 6 and 775 ns for 7.
// - fd bit 5 suspends the error counter during selective wake, only while fd mode is on.
// - the suspend bit is cleared by the device itself when the bus silence timeout expires.
// - trim bit 14 picks low-power (0) or standard (1) receiver, reachable only with key 11.
// - trim bits 11:7 hold the temperature trim and take writes only with key 11.
// - trim bits 6:0 hold the oscillator trim and take writes only with key 11.
// - reserved bits of the fd and trim registers always read as zero.
// - the configured length code is compared bit by bit with the received one, 8..15 mean 8.
module wfp_config
	import wfp_pkg::*;
(
	// clock, reset, enable
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ce,
	// register access
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [DATA_W-1:0] reg_rdata_q,
	output logic reg_rvalid_q,
	// device status in
	input wire logic [1:0] trim_key,
	input wire logic silence_expired,
	// wake frame compare
	input wire logic [3:0] cfg_dlc,
	input wire logic [3:0] rx_dlc,
	input wire logic [PAY_BYTES*8-1:0] rx_data,
	input wire logic rx_frame_valid,
	output logic frame_match_q,
	output logic match_valid_q,
	// configuration out
	output logic fd_tolerant_enable_q,
	output logic [FD_FILT_W-1:0] dominant_filter_time_q,
	output logic [FILT_CYC_W-1:0] filter_cycles_q,
	output logic error_counter_suspend_q,
	output logic wake_receiver_select_q,
	output logic [TRIM_TC_W-1:0] temp_coef_trim_q,
	output logic [OSC_TRIM_W-1:0] oscillator_frequency_trim_q
);
	// ****************************************************************
	// register state
	// ****************************************************************
	logic susp_q, susp_d;
	logic fd_en_d, susp_eff_d, rxsel_d;
	logic [2:0] filt_d;
	logic [6:0] filt_cyc_d, osc_d;
	logic [4:0] tc_d;
	logic rd_pend_q, rd_pend_d, rvalid_d;
	logic [6:0] rd_addr_q, rd_addr_d;
	logic [15:0] rdata_d;
	logic wr_fd, wr_trim, wr_pay, key_open;
	logic [1:0] wr_idx, rd_idx;
	logic [15:0] pay_rdata_q;
	logic [PAY_BYTES*8-1:0] payload;
	logic match_d, mvalid_d;
	logic [3:0] len;

	assign key_open = (trim_key == TRIM_KEY_OPEN);
	assign wr_fd = reg_wr && (reg_addr == ADDR_FD_CFG);
	assign wr_trim = reg_wr && (reg_addr == ADDR_TRIM) && key_open;
	assign wr_pay = reg_wr && (reg_addr >= ADDR_PAY_7_6) && (reg_addr <= ADDR_PAY_1_0);
	assign wr_idx = 2'(ADDR_PAY_1_0 - reg_addr);
	assign rd_idx = 2'(ADDR_PAY_1_0 - reg_addr);

	// ****************************************************************
	// payload store
	// ****************************************************************
	wfp_payload_store #(
		.WORDS(PAY_WORDS)
	) u_store (
		.clk(clk),
		.rst_b(rst_b),
		.ce(ce),
		.wr_en(wr_pay),
		.wr_idx(wr_idx),
		.wr_data(reg_wdata),
		.rd_idx(rd_idx),
		.rd_data_q(pay_rdata_q),
		.flat(payload)
	);

	// ****************************************************************
	// configuration next state
	// ****************************************************************
	always_comb begin
		fd_en_d = fd_tolerant_enable_q;
		filt_d = dominant_filter_time_q;
		susp_d = susp_q;
		rxsel_d = wake_receiver_select_q;
		tc_d = temp_coef_trim_q;
		osc_d = oscillator_frequency_trim_q;
		if (wr_fd) begin
			fd_en_d = reg_wdata[FD_EN_BIT];
			filt_d = reg_wdata[FD_FILT_LSB +: FD_FILT_W];
			susp_d = reg_wdata[FD_SUSP_BIT];
		end
		if (silence_expired) begin
			susp_d = 1'b0;
		end
		if (wr_trim) begin
			rxsel_d = reg_wdata[TRIM_RXSEL_BIT];
			tc_d = reg_wdata[TRIM_TC_LSB +: TRIM_TC_W];
			osc_d = reg_wdata[OSC_TRIM_LSB +: OSC_TRIM_W];
		end
		filt_cyc_d = wfp_filter_cycles(filt_d);
		susp_eff_d = susp_d && fd_en_d;
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			fd_tolerant_enable_q <= FD_RESET[FD_EN_BIT];
			dominant_filter_time_q <= FD_RESET[FD_FILT_LSB +: FD_FILT_W];
			susp_q <= FD_RESET[FD_SUSP_BIT];
			error_counter_suspend_q <= 1'b0;
			filter_cycles_q <= FILT_SHORT_CYC;
			wake_receiver_select_q <= TRIM_RESET[TRIM_RXSEL_BIT];
			temp_coef_trim_q <= TRIM_RESET[TRIM_TC_LSB +: TRIM_TC_W];
			oscillator_frequency_trim_q <= TRIM_RESET[OSC_TRIM_LSB +: OSC_TRIM_W];
		end else if (ce) begin
			fd_tolerant_enable_q <= fd_en_d;
			dominant_filter_time_q <= filt_d;
			susp_q <= susp_d;
			error_counter_suspend_q <= susp_eff_d;
			filter_cycles_q <= filt_cyc_d;
			wake_receiver_select_q <= rxsel_d;
			temp_coef_trim_q <= tc_d;
			oscillator_frequency_trim_q <= osc_d;
		end
	end

	// ****************************************************************
	// read path
	// ****************************************************************
	always_comb begin
		rd_pend_d = reg_rd;
		rd_addr_d = reg_rd ? reg_addr : rd_addr_q;
		rvalid_d = rd_pend_q;
		rdata_d = reg_rdata_q;
		if (rd_pend_q) begin
			case (rd_addr_q)
				ADDR_PAY_7_6, ADDR_PAY_5_4, ADDR_PAY_3_2, ADDR_PAY_1_0: begin
					rdata_d = pay_rdata_q;
				end
				ADDR_FD_CFG: begin
					rdata_d = FD_READ_MASK & {10'h000, susp_q, 1'b0, dominant_filter_time_q,
						fd_tolerant_enable_q};
				end
				ADDR_TRIM: begin
					rdata_d = TRIM_READ_MASK & {1'b0, wake_receiver_select_q & key_open, 2'h0,
						temp_coef_trim_q, oscillator_frequency_trim_q};
				end
				default: begin
					rdata_d = 16'h0000;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			rd_pend_q <= 1'b0;
			rd_addr_q <= 7'h00;
			reg_rvalid_q <= 1'b0;
			reg_rdata_q <= 16'h0000;
		end else if (ce) begin
			rd_pend_q <= rd_pend_d;
			rd_addr_q <= rd_addr_d;
			reg_rvalid_q <= rvalid_d;
			reg_rdata_q <= rdata_d;
		end
	end

	// ****************************************************************
	// wake frame compare
	// ****************************************************************
	always_comb begin
		len = cfg_dlc[3] ? DLC_MAX_BYTES : cfg_dlc;
		match_d = (rx_dlc == cfg_dlc);
		for (int i = 0; i < PAY_BYTES; i++) begin
			if ((4'(i) < len) && (payload[i*8 +: 8] != rx_data[i*8 +: 8])) begin
				match_d = 1'b0;
			end
		end
		mvalid_d = rx_frame_valid;
		if (!rx_frame_valid) begin
			match_d = frame_match_q;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			frame_match_q <= 1'b0;
			match_valid_q <= 1'b0;
		end else if (ce) begin
			frame_match_q <= match_d;
			match_valid_q <= mvalid_d;
		end
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	sequence fd_read_s;
		ce && reg_rd && (reg_addr == ADDR_FD_CFG) ##1 ce;
	endsequence
	sequence trim_read_s;
		ce && reg_rd && (reg_addr == ADDR_TRIM) ##1 ce;
	endsequence

	pay_write_a: assert property (ce && reg_wr && (reg_addr == ADDR_PAY_1_0) |=>
		payload[15:0] == $past(reg_wdata))
		else $error("payload word for bytes one and zero not written");
	fd_enable_a: assert property (ce && wr_fd |=>
		fd_tolerant_enable_q == $past(reg_wdata[FD_EN_BIT]))
		else $error("fd enable not taken from write");
	filt_time_a: assert property ((dominant_filter_time_q == 3'h7) |->
		(filter_cycles_q == 7'h4E))
		else $error("long filter time wrong");
	filt_step_a: assert property ((dominant_filter_time_q == 3'h2) |->
		(filter_cycles_q == 7'h0F))
		else $error("filter step time wrong");
	susp_gate_a: assert property (error_counter_suspend_q |->
		(fd_tolerant_enable_q && susp_q))
		else $error("suspend active without fd mode");
	silence_clr_a: assert property (ce && silence_expired |=>
		!susp_q && !error_counter_suspend_q)
		else $error("suspend bit kept after silence timeout");
	rxsel_lock_a: assert property (ce && reg_wr && (reg_addr == ADDR_TRIM) && !key_open |=>
		$stable(wake_receiver_select_q))
		else $error("receiver select changed while locked");
	trim_lock_a: assert property (ce && reg_wr && (reg_addr == ADDR_TRIM) && !key_open |=>
		$stable(temp_coef_trim_q) && $stable(oscillator_frequency_trim_q))
		else $error("trim changed while locked");
	fd_resv_a: assert property (fd_read_s |=>
		reg_rvalid_q && ((reg_rdata_q & ~FD_READ_MASK) == 16'h0000))
		else $error("fd reserved bits not zero");
	trim_resv_a: assert property (trim_read_s |=>
		reg_rvalid_q && ((reg_rdata_q & ~TRIM_READ_MASK) == 16'h0000))
		else $error("trim reserved bits not zero");
	dlc_miss_a: assert property (ce && rx_frame_valid && (rx_dlc != cfg_dlc) |=>
		match_valid_q && !frame_match_q)
		else $error("match despite length code mismatch");
	len_zero_a: assert property (ce && rx_frame_valid && (cfg_dlc == 4'h0) && (rx_dlc == 4'h0) |=>
		frame_match_q)
		else $error("zero length frame not matched");
endmodule : wfp_config
`default_nettype wire

// ==== tb/wfp_host.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// host register access model
// ****************************************************************
module wfp_host
	import wfp_pkg::*;
(
	// clock
	input wire logic clk,
	// register port
	output logic [ADDR_W-1:0] reg_addr,
	output logic [DATA_W-1:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [DATA_W-1:0] reg_rdata_q,
	input wire logic reg_rvalid_q
);
	initial begin
		reg_addr = '0;
		reg_wdata = '0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end

	// one-cycle write strobe; data flipped once it is no longer qualified
	task automatic wr(input logic [6:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_wdata <= ~d;
	endtask : wr

	// one-cycle read strobe, bounded wait for the valid pulse
	task automatic rd(input logic [6:0] a, output logic [15:0] d, output logic ok);
		int n;
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		ok = 1'b0;
		d = '0;
		for (n = 0; n < 8 && !ok; n++) begin
			#1;
			if (reg_rvalid_q === 1'b1) begin
				ok = 1'b1;
				d = reg_rdata_q;
			end else begin
				@(posedge clk);
			end
		end
	endtask : rd
endmodule : wfp_host
`default_nettype wire

// ==== tb/wake_frame_payload_fd_config_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// register bank bench
// ****************************************************************
module wake_frame_payload_fd_config_tb
	import wfp_pkg::*;
;
	typedef struct {logic [6:0] a; logic [15:0] d; logic [1:0] k; logic [15:0] e;} wfp_row_t;
	logic clk, rst_b, ce, reg_wr, reg_rd, reg_rvalid_q, silence_expired, rx_frame_valid;
	logic [ADDR_W-1:0] reg_addr;
	logic [DATA_W-1:0] reg_wdata, reg_rdata_q;
	logic [1:0] trim_key;
	logic [3:0] cfg_dlc, rx_dlc;
	logic [63:0] rx_data;
	logic frame_match_q, match_valid_q, fd_en, susp, rx_sel;
	logic [2:0] filt;
	logic [6:0] filt_cyc, osc;
	logic [4:0] tc;
	int error_cnt = 0;
	int checked = 0;
	wfp_row_t rows [8] = '{
		'{7'h37, 16'h1234, 2'h0, 16'h1234}, '{7'h38, 16'h5678, 2'h0, 16'h5678},
		'{7'h39, 16'h9ABC, 2'h0, 16'h9ABC}, '{7'h3A, 16'hDEF0, 2'h0, 16'hDEF0},
		'{7'h3B, 16'hFFFF, 2'h0, 16'h002F}, '{7'h3C, 16'hFFFF, 2'h3, 16'h4FFF},
		'{7'h3C, 16'h0000, 2'h0, 16'h0FFF}, '{7'h3D, 16'hFFFF, 2'h0, 16'h0000}};

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	wfp_host u_host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q));

	wfp_config u_dut (.clk(clk), .rst_b(rst_b), .ce(ce), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
		.reg_rvalid_q(reg_rvalid_q), .trim_key(trim_key), .silence_expired(silence_expired),
		.cfg_dlc(cfg_dlc), .rx_dlc(rx_dlc), .rx_data(rx_data), .rx_frame_valid(rx_frame_valid),
		.frame_match_q(frame_match_q), .match_valid_q(match_valid_q),
		.fd_tolerant_enable_q(fd_en), .dominant_filter_time_q(filt), .filter_cycles_q(filt_cyc),
		.error_counter_suspend_q(susp), .wake_receiver_select_q(rx_sel),
		.temp_coef_trim_q(tc), .oscillator_frequency_trim_q(osc));

	task automatic report_and_stop();
		if (error_cnt == 0 && checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : report_and_stop

	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp

	task automatic rdc(input logic [6:0] a, input logic [15:0] exp);
		logic [15:0] d;
		logic ok;
		u_host.rd(a, d, ok);
		if (!ok) begin
			error_cnt++;
			report_and_stop();
		end
		cmp(d, exp);
	endtask : rdc

	task automatic frame(input logic [3:0] c, input logic [3:0] r, input logic [63:0] d,
		input logic e);
		@(posedge clk);
		cfg_dlc <= c;
		rx_dlc <= r;
		rx_data <= d;
		rx_frame_valid <= 1'b1;
		@(posedge clk);
		rx_frame_valid <= 1'b0;
		#1;
		cmp(16'(match_valid_q), 16'h0001);
		cmp(16'(frame_match_q), 16'(e));
	endtask : frame

	initial begin
		rst_b = 1'b0;
		ce = 1'b1;
		trim_key = 2'h0;
		silence_expired = 1'b0;
		cfg_dlc = 4'h0;
		rx_dlc = 4'h0;
		rx_data = '0;
		rx_frame_valid = 1'b0;
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		// ****************************************************************
		// table rows: write, read back
		// ****************************************************************
		foreach (rows[i]) begin
			trim_key <= rows[i].k;
			u_host.wr(rows[i].a, rows[i].d);
			rdc(rows[i].a, rows[i].e);
		end
		cmp(16'({rx_sel, tc, osc}), 16'h1FFF);
		trim_key <= 2'h3;
		u_host.wr(ADDR_TRIM, 16'h0FFF);
		#1;
		cmp(16'(rx_sel), 16'h0000);
		// ****************************************************************
		// filter codes and suspend bit
		// ****************************************************************
		for (int c = 0; c < 8; c++) begin
			u_host.wr(ADDR_FD_CFG, 16'({c[2:0], 1'b1}));
			#1;
			cmp(16'({fd_en, filt}), 16'({1'b1, c[2:0]}));
			cmp(16'(filt_cyc), (c == 7) ? 16'h004E : 16'(5 * (c + 1)));
		end
		u_host.wr(ADDR_FD_CFG, 16'h0020);
		#1;
		cmp(16'({fd_en, susp}), 16'h0000);
		u_host.wr(ADDR_FD_CFG, 16'h0021);
		#1;
		cmp(16'(susp), 16'h0001);
		@(posedge clk);
		silence_expired <= 1'b1;
		@(posedge clk);
		silence_expired <= 1'b0;
		#1;
		cmp(16'(susp), 16'h0000);
		rdc(ADDR_FD_CFG, 16'h0001);
		// ****************************************************************
		// clock enable low freezes the registers
		// ****************************************************************
		@(posedge clk);
		ce <= 1'b0;
		u_host.wr(ADDR_FD_CFG, 16'h000E);
		ce <= 1'b1;
		#1;
		cmp(16'({fd_en, filt}), 16'h0008);
		// ****************************************************************
		// wake frame compare
		// ****************************************************************
		frame(4'h8, 4'h8, 64'h1234_5678_0FFF_DEF0, 1'b0);
		trim_key <= 2'h0;
		u_host.wr(ADDR_PAY_3_2, 16'h9ABC);
		frame(4'h8, 4'h8, 64'h1234_5678_9ABC_DEF0, 1'b1);
		frame(4'hF, 4'hF, 64'h1234_5678_9ABC_DEF0, 1'b1);
		frame(4'h9, 4'h8, 64'h1234_5678_9ABC_DEF0, 1'b0);
		frame(4'h8, 4'h8, 64'h0034_5678_9ABC_DEF0, 1'b0);
		frame(4'h2, 4'h2, 64'hFFFF_FFFF_FFFF_DEF0, 1'b1);
		frame(4'h2, 4'h2, 64'h0000_0000_0000_DEF1, 1'b0);
		frame(4'h0, 4'h0, 64'h0000_0000_0000_0000, 1'b1);
		// ****************************************************************
		// reset in mid-run
		// ****************************************************************
		@(posedge clk);
		rst_b <= 1'b0;
		@(posedge clk);
		rst_b <= 1'b1;
		trim_key <= 2'h3;
		#1;
		cmp(16'(filt_cyc), 16'h0005);
		cmp(16'({frame_match_q, match_valid_q, reg_rvalid_q}), 16'h0000);
		for (int a = 'h37; a <= 'h3C; a++) begin
			rdc(7'(a), 16'h0000);
		end
		report_and_stop();
	end
endmodule : wake_frame_payload_fd_config_tb
`default_nettype wire
